// ### hdl/epiu_pkg.sv
/*
  constants for the external pin interrupt unit: register offsets, field
  positions, reset values, sense codes and vector addresses.
  assumes: included before hdl/epiu_core.sv, used only by scoped reference.
*/
package epiu_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_SENSE_CONTROL = 3'h0;
  localparam logic [2:0] OFF_IRQ_ENABLE_MASK = 3'h1;
  localparam logic [2:0] OFF_IRQ_FLAG_BANK = 3'h2;
  localparam logic [2:0] OFF_CHANGE_MASK_HIGH = 3'h3;
  localparam logic [2:0] OFF_CHANGE_MASK_LOW = 3'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SENSE_SELECT_LO_BIT = 6;
  localparam int SENSE_SELECT_HI_BIT = 7;
  localparam int DEDICATED_BIT = 0;
  localparam int GROUP_LOW_BIT = 4;
  localparam int GROUP_HIGH_BIT = 5;
  localparam int LOW_GROUP_PINS = 8;
  localparam int HIGH_GROUP_PINS = 4;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SENSE_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RST_CHANGE_MASK_LOW = 8'h00;
  localparam logic [3:0] RST_CHANGE_MASK_HIGH = 4'h0;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  // ----------------------------------------------------------------
  // vector program addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_DEDICATED = 16'h0001;
  localparam logic [15:0] VEC_GROUP_LOW = 16'h0002;
  localparam logic [15:0] VEC_GROUP_HIGH = 16'h0003;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  // sense select codes of the dedicated pin
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY_CHANGE = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING = 2'h3
  } epiu_sense_e;

endpackage

// ### hdl/epiu_core.sv
/*
  external pin interrupt unit: one dedicated interrupt pin with selectable
  sense and twelve pin-change inputs in two masked groups, with enables,
  sticky flags, a register port and a vector request to the core.
  assumes: one clock clk_sys, pins asynchronous to it, core gives the global
  enable level and a one-cycle acknowledge of the presented vector.
*/
// What this block does
// (RULE1) pin activity interrupts even when pin drives
// (RULE2) masked toggle on inputs 0-7 requests
// (RULE3) masked toggle on inputs 8-11 requests
// (RULE4) change detection wakes without running clock
// (RULE5) low level keeps requesting while pin low
// (RULE6) edges need clock, low level does not
// (RULE7) low removed early: wake, no interrupt
// (RULE8) sense field bits 7:6 selects trigger
// (RULE9) pin sampled, longer pulses always detected
// (RULE10) driver holds low until instruction completes
// (RULE11) dedicated vector needs enable bit 0, global
// (RULE12) high group needs enable bit 5, global
// (RULE13) low group needs enable bit 4, global
// (RULE14) high flag bit 5: set, ack/w1c clears
// (RULE15) low flag bit 4: set, ack/w1c clears
// (RULE16) dedicated flag bit 0, cleared in level mode
// (RULE17) high mask bits 3:0 gate each pin
// (RULE18) low mask bits 7:0 gate each pin
// (RULE19) reserved bits read back as zero
// (RULE20) vectors at 0x0001, 0x0002, 0x0003
// (RULE21) edge: compare current and previous sample
`timescale 1ns/10ps
`default_nettype none

module epiu_core #(
  parameter int N_CHANGE = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pad levels, seen whatever the pin direction
  input wire logic dedicated_irq_pin,
  input wire logic [N_CHANGE-1:0] change_inputs,
  // core side
  input wire logic status_word_gie,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [15:0] irq_addr,
  output logic change_group_low_request,
  output logic change_group_high_request,
  // clockless wake to the sleep controller
  output logic wake_req
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sense_control;   // bits 7:6 sense, rest stored
    logic [7:0] irq_enable_mask; // only bits 5,4,0 kept
    logic [2:0] flags;           // {high, low, dedicated}
    logic [3:0] change_mask_high;
    logic [7:0] change_mask_low;
    logic pin_s1;                // synchroniser first stage
    logic pin_s2;                // synchronised pin
    logic pin_prev;              // previous synchronised sample
    logic [N_CHANGE-1:0] chg_s1;
    logic [N_CHANGE-1:0] chg_s2;
    logic [N_CHANGE-1:0] chg_prev;
    logic [7:0] rdata;
    logic req;
    logic [15:0] addr;
    logic low_req;
    logic high_req;
  } epiu_state_s;

  epiu_state_s s_r;
  epiu_state_s s_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // any masked pin whose two samples differ
  function automatic logic any_change(input logic [7:0] cur, input logic [7:0] prev,
                                      input logic [7:0] mask);
    any_change = |((cur ^ prev) & mask);
  endfunction

  // decoded fields and per-cycle events
  epiu_pkg::epiu_sense_e sense;  // decoded sense select
  logic en_ded;                  // dedicated enable
  logic en_low;                  // low group enable
  logic en_high;                 // high group enable
  logic set_ded;                 // dedicated flag set event
  logic set_low;                 // low group flag set event
  logic set_high;                // high group flag set event
  logic level_active;            // level mode, pin held low
  logic [2:0] clr_w1c;           // software clear
  logic [2:0] clr_ack;           // clear by vector execution
  logic [7:0] rd_mux;            // read data before register

  // field decode shared by the datapath and the checks
  always_comb begin
    // (RULE8) sense field decode
    sense = epiu_pkg::epiu_sense_e'(s_r.sense_control[epiu_pkg::SENSE_SELECT_HI_BIT:
                                                      epiu_pkg::SENSE_SELECT_LO_BIT]);
    en_ded = s_r.irq_enable_mask[epiu_pkg::DEDICATED_BIT];
    en_low = s_r.irq_enable_mask[epiu_pkg::GROUP_LOW_BIT];
    en_high = s_r.irq_enable_mask[epiu_pkg::GROUP_HIGH_BIT];
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  always_comb begin
    // (RULE21) edge from two samples
    // (RULE9) pulses over one period caught
    case (sense)
      epiu_pkg::SENSE_ANY_CHANGE: set_ded = s_r.pin_s2 ^ s_r.pin_prev;
      epiu_pkg::SENSE_FALLING: set_ded = s_r.pin_prev & ~s_r.pin_s2;
      epiu_pkg::SENSE_RISING: set_ded = ~s_r.pin_prev & s_r.pin_s2;
      default: set_ded = 1'b0;
    endcase
    // (RULE2) low group toggle
    // (RULE18) per pin mask, group enable
    set_low = en_low & any_change(s_r.chg_s2[7:0], s_r.chg_prev[7:0], s_r.change_mask_low);
    // (RULE3) high group toggle
    // (RULE17) per pin mask, group enable
    set_high = en_high & any_change({4'h0, s_r.chg_s2[11:8]}, {4'h0, s_r.chg_prev[11:8]},
                                    {4'h0, s_r.change_mask_high});
    // (RULE5) level request while low
    // (RULE7) no latching: early release leaves nothing
    // (RULE10) relies on driver holding low
    level_active = (sense == epiu_pkg::SENSE_LOW_LEVEL) & ~s_r.pin_s2;
  end

  // (RULE4) change wake without clock
  // (RULE6) level wake without clock
  // this path reads the raw pads on purpose: in deep sleep no edge arrives
  always_comb begin
    wake_req = (en_ded & (sense == epiu_pkg::SENSE_LOW_LEVEL) & ~dedicated_irq_pin)
             | (en_low & |((change_inputs[7:0] ^ s_r.chg_s2[7:0]) & s_r.change_mask_low))
             | (en_high & |((change_inputs[11:8] ^ s_r.chg_s2[11:8]) & s_r.change_mask_high));
  end

  // ----------------------------------------------------------------
  // clears and read mux
  // ----------------------------------------------------------------
  always_comb begin
    // write one to clear the flag bank
    clr_w1c = 3'h0;
    if (reg_wr && reg_addr == epiu_pkg::OFF_IRQ_FLAG_BANK) begin
      clr_w1c = {reg_wdata[epiu_pkg::GROUP_HIGH_BIT], reg_wdata[epiu_pkg::GROUP_LOW_BIT],
                 reg_wdata[epiu_pkg::DEDICATED_BIT]};
    end
    // ack clears the flag of the vector shown
    clr_ack = 3'h0;
    if (irq_ack && s_r.req) begin
      case (s_r.addr)
        epiu_pkg::VEC_DEDICATED: clr_ack = 3'h1;
        epiu_pkg::VEC_GROUP_LOW: clr_ack = 3'h2;
        epiu_pkg::VEC_GROUP_HIGH: clr_ack = 3'h4;
        default: clr_ack = 3'h0;
      endcase
    end
    // (RULE19) reserved bits read as zero
    case (reg_addr)
      epiu_pkg::OFF_SENSE_CONTROL: rd_mux = s_r.sense_control;
      epiu_pkg::OFF_IRQ_ENABLE_MASK: rd_mux = s_r.irq_enable_mask & 8'h31;
      epiu_pkg::OFF_IRQ_FLAG_BANK: rd_mux = {2'h0, s_r.flags[2], s_r.flags[1], 3'h0, s_r.flags[0]};
      epiu_pkg::OFF_CHANGE_MASK_HIGH: rd_mux = {4'h0, s_r.change_mask_high};
      epiu_pkg::OFF_CHANGE_MASK_LOW: rd_mux = s_r.change_mask_low;
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // (RULE1) pads sampled regardless of direction
    s_nxt.pin_s1 = dedicated_irq_pin;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_prev = s_r.pin_s2;
    s_nxt.chg_s1 = change_inputs;
    s_nxt.chg_s2 = s_r.chg_s1;
    s_nxt.chg_prev = s_r.chg_s2;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        epiu_pkg::OFF_SENSE_CONTROL: s_nxt.sense_control = reg_wdata;
        epiu_pkg::OFF_IRQ_ENABLE_MASK: s_nxt.irq_enable_mask = reg_wdata & 8'h31;
        epiu_pkg::OFF_CHANGE_MASK_HIGH: s_nxt.change_mask_high = reg_wdata[3:0];
        epiu_pkg::OFF_CHANGE_MASK_LOW: s_nxt.change_mask_low = reg_wdata;
        default: s_nxt.sense_control = s_r.sense_control;
      endcase
    end
    // (RULE14) high flag, set wins over clear
    s_nxt.flags[2] = (s_r.flags[2] & ~(clr_w1c[2] | clr_ack[2])) | set_high;
    // (RULE15) low flag, set wins over clear
    s_nxt.flags[1] = (s_r.flags[1] & ~(clr_w1c[1] | clr_ack[1])) | set_low;
    // (RULE16) dedicated flag, held clear in level mode
    if (sense == epiu_pkg::SENSE_LOW_LEVEL) begin
      s_nxt.flags[0] = 1'b0;
    end else begin
      s_nxt.flags[0] = (s_r.flags[0] & ~(clr_w1c[0] | clr_ack[0])) | set_ded;
    end
    // read data valid one cycle after the strobe
    s_nxt.rdata = reg_rd ? rd_mux : 8'h00;
    // group requests follow flag and enable
    s_nxt.low_req = s_r.flags[1] & en_low;
    s_nxt.high_req = s_r.flags[2] & en_high;
    // (RULE11) dedicated needs bit 0 and global
    // (RULE13) low group needs bit 4 and global
    // (RULE12) high group needs bit 5 and global
    // (RULE20) fixed vector, dedicated first
    s_nxt.req = 1'b1;
    if (status_word_gie && en_ded && (s_r.flags[0] || level_active)) begin
      s_nxt.addr = epiu_pkg::VEC_DEDICATED;
    end else if (status_word_gie && en_low && s_r.flags[1]) begin
      s_nxt.addr = epiu_pkg::VEC_GROUP_LOW;
    end else if (status_word_gie && en_high && s_r.flags[2]) begin
      s_nxt.addr = epiu_pkg::VEC_GROUP_HIGH;
    end else begin
      s_nxt.req = 1'b0;
      s_nxt.addr = epiu_pkg::VEC_NONE;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.sense_control <= epiu_pkg::RST_SENSE_CONTROL;
      s_r.irq_enable_mask <= epiu_pkg::RST_IRQ_ENABLE_MASK;
      s_r.flags <= epiu_pkg::RST_FLAGS;
      s_r.change_mask_high <= epiu_pkg::RST_CHANGE_MASK_HIGH;
      s_r.change_mask_low <= epiu_pkg::RST_CHANGE_MASK_LOW;
      s_r.addr <= epiu_pkg::VEC_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign irq_req = s_r.req;
  assign irq_addr = s_r.addr;
  assign change_group_low_request = s_r.low_req;
  assign change_group_high_request = s_r.high_req;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_level_flag_clear: assert property (sense == epiu_pkg::SENSE_LOW_LEVEL |=> !s_r.flags[0]) // RULE16
    else $error("dedicated flag set in level mode");
  a_level_keeps_req: assert property ((level_active && en_ded && status_word_gie)[*2]
      |=> irq_req && irq_addr == 16'h0001) // RULE5
    else $error("level low without dedicated request");
  a_fall_sets_flag: assert property (($fell(s_r.pin_s2) && sense == epiu_pkg::SENSE_FALLING)
      |=> s_r.flags[0]) // RULE9
    else $error("falling edge missed");
  a_rise_sets_flag: assert property ((!s_r.pin_prev && s_r.pin_s2 && sense == epiu_pkg::SENSE_RISING)
      |=> s_r.flags[0]) // RULE21
    else $error("rising edge missed");
  a_pin_to_flag: assert property ((sense == epiu_pkg::SENSE_ANY_CHANGE && !reg_wr)[*2]
      ##0 $changed(dedicated_irq_pin) |-> ##[3:3] s_r.flags[0]) // RULE1
    else $error("pad change not flagged after sync");
  a_low_group_set: assert property ((en_low && |((s_r.chg_s2[7:0] ^ s_r.chg_prev[7:0]) & s_r.change_mask_low))
      |=> s_r.flags[1] ##1 change_group_low_request) // RULE2
    else $error("low group toggle not flagged");
  a_high_group_set: assert property (set_high |=> s_r.flags[2] ##1 change_group_high_request) // RULE3
    else $error("high group toggle not flagged");
  a_high_w1c_clear: assert property ((reg_wr && reg_addr == 3'h2 && reg_wdata[5] && !set_high)
      |=> !s_r.flags[2]) // RULE14
    else $error("high flag not cleared by write one");
  a_low_ack_clear: assert property ((irq_ack && irq_req && irq_addr == 16'h0002 && !set_low)
      |=> !s_r.flags[1]) // RULE15
    else $error("low flag not cleared by ack");
  a_gie_off_no_req: assert property (!status_word_gie |=> !irq_req) // RULE11
    else $error("request with global enable off");
  a_high_needs_en: assert property ((!en_high || !status_word_gie)
      && !(en_ded && (s_r.flags[0] || level_active)) && !(en_low && s_r.flags[1])
      |=> !irq_req) // RULE12
    else $error("high request without enable");
  a_low_needs_en: assert property (irq_req && irq_addr == 16'h0002 |-> $past(en_low)) // RULE13
    else $error("low request without enable");
  a_vector_range: assert property (irq_req |-> irq_addr inside {16'h0001, 16'h0002, 16'h0003}) // RULE20
    else $error("vector address out of range");
  a_reserved_zero: assert property (reg_rd && reg_addr == 3'h2 |=> reg_rdata[7:6] == 2'h0
      && reg_rdata[3:1] == 3'h0) // RULE19
    else $error("reserved flag bits not zero");
  a_wake_level: assert property (en_ded && sense == epiu_pkg::SENSE_LOW_LEVEL
      && !dedicated_irq_pin |-> wake_req) // RULE6
    else $error("no wake on low level");
  a_mask_gates_pin: assert property ((s_r.change_mask_low == 8'h00 && s_r.change_mask_high == 4'h0
      && !s_r.flags[1] && !s_r.flags[2]) |=> !s_r.flags[1] && !s_r.flags[2]) // RULE17
    else $error("masked pin set a group flag");

  c_fall_vector: cover property (sense == epiu_pkg::SENSE_FALLING ##1 irq_req && irq_addr == 16'h0001);
  c_level_vector: cover property (level_active ##1 irq_req && irq_addr == 16'h0001);
  c_low_group_ack: cover property (irq_ack && irq_addr == 16'h0002);
  c_high_group_req: cover property (irq_req && irq_addr == 16'h0003);

endmodule

`default_nettype wire

// ### sim/epiu_core_model.sv
/*
  model of the processor core side: takes presented vectors and logs them.
  assumes: same clock and reset as the interrupt unit.
*/
`timescale 1ns/10ps
`default_nettype none

module epiu_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control from the bench
  input wire logic ack_en,
  // vector handshake
  input wire logic irq_req,
  input wire logic [15:0] irq_addr,
  output logic irq_ack,
  // record of vectors taken, oldest in the top word
  output logic [1:0] n_taken,
  output logic [47:0] taken_log
);
  logic [1:0] hold_r; // cycles left before another ack

  // ----------------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------------
  // one-cycle ack, then a pause so the cleared flag drops the request
  // before it is looked at again; logs at most three vectors
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      hold_r <= 2'h0;
      n_taken <= 2'h0;
      taken_log <= 48'h0;
    end else if (hold_r != 2'h0) begin
      irq_ack <= 1'b0;
      hold_r <= hold_r - 2'h1;
    end else if (ack_en && irq_req && n_taken != 2'h3) begin
      irq_ack <= 1'b1;
      hold_r <= 2'h3;
      n_taken <= n_taken + 2'h1;
      taken_log <= {taken_log[31:0], irq_addr};
    end
  end
endmodule

`default_nettype wire

// ### sim/tb.sv
/*
  testbench of the external pin interrupt unit: registers, sense modes,
  change groups and vector order through the register port and pads.
  assumes: hdl/epiu_pkg.sv, hdl/epiu_core.sv, sim/epiu_core_model.sv first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [2:0] A_SC = epiu_pkg::OFF_SENSE_CONTROL; // offset aliases
  localparam logic [2:0] A_EN = epiu_pkg::OFF_IRQ_ENABLE_MASK;
  localparam logic [2:0] A_FL = epiu_pkg::OFF_IRQ_FLAG_BANK;
  localparam logic [2:0] A_MH = epiu_pkg::OFF_CHANGE_MASK_HIGH;
  localparam logic [2:0] A_ML = epiu_pkg::OFF_CHANGE_MASK_LOW;
  logic clk_sys, rst_b, reg_wr, reg_rd; // clock, reset, strobes
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic ded_pin; // pads
  logic [11:0] chg;
  logic gie, ack_en, irq_ack, irq_req, lo_req, hi_req, wake_req; // core side
  logic [15:0] irq_addr;
  logic [1:0] n_taken;
  logic [47:0] taken_log;
  logic [11:0] mk; // change masks in use
  int n_errors, checks, wait_n;

  epiu_core #(.N_CHANGE(12)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dedicated_irq_pin(ded_pin), .change_inputs(chg), .status_word_gie(gie), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_addr(irq_addr), .change_group_low_request(lo_req),
    .change_group_high_request(hi_req), .wake_req(wake_req));

  epiu_core_model u_far (.clk_sys(clk_sys), .rst_b(rst_b), .ack_en(ack_en), .irq_req(irq_req),
    .irq_addr(irq_addr), .irq_ack(irq_ack), .n_taken(n_taken), .taken_log(taken_log));

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one-cycle write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read, data checked in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "read data");
  endtask

  // set pads and hold them well past the sync and flag delay
  task automatic pins(input logic d, input logic [11:0] c);
    @(posedge clk_sys);
    ded_pin <= d;
    chg <= c;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  // verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    checks = 0;
    rst_b <= 1'b0;
    reg_addr <= 3'h0;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    ded_pin <= 1'b1;
    chg <= 12'h000;
    gie <= 1'b0;
    ack_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    // reset values, unmapped place, reserved bits
    for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    wr(A_SC, 8'hff);
    rd(A_SC, 8'hff);
    wr(A_EN, 8'hff);
    rd(A_EN, 8'h31);
    wr(A_MH, 8'hff);
    rd(A_MH, 8'h0f);
    wr(A_ML, 8'hff);
    rd(A_ML, 8'hff);
    wr(A_FL, 8'hff);
    rd(A_FL, 8'h00);
    $display("test registers done");
    // edge modes: any change, falling, rising
    wr(A_EN, 8'h01);
    for (int m = 1; m < 4; m++) begin
      wr(A_SC, {m[1:0], 6'h00});
      wr(A_FL, 8'h01);
      pins(1'b0, chg);
      rd(A_FL, {7'h00, m != 3});
      wr(A_FL, 8'h01);
      pins(1'b1, chg);
      rd(A_FL, {7'h00, m != 2});
    end
    $display("test edge modes done");
    // low level mode
    wr(A_SC, 8'h00);
    @(posedge clk_sys);
    gie <= 1'b1;
    pins(1'b0, chg);
    chk(irq_req, 1'b1, "level request");
    chk(irq_addr, epiu_pkg::VEC_DEDICATED, "level vector");
    chk(wake_req, 1'b1, "level wake");
    rd(A_FL, 8'h00);
    chk(irq_req, 1'b1, "level held");
    @(posedge clk_sys);
    gie <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(irq_req, 1'b0, "global off");
    pins(1'b1, chg);
    chk(wake_req, 1'b0, "wake idle");
    $display("test level mode done");
    // change groups, every input once, alternate masks
    wr(A_SC, 8'h80);
    wr(A_EN, 8'h30);
    wr(A_ML, 8'h55);
    wr(A_MH, 8'h05);
    mk = 12'h555;
    for (int i = 0; i < 12; i++) begin
      // pad moves, raw wake shows before the sync stages catch up
      @(posedge clk_sys);
      chg <= chg ^ (12'h001 << i);
      #1;
      chk(wake_req, mk[i], "change wake");
      pins(1'b1, chg);
      rd(A_FL, !mk[i] ? 8'h00 : (i < 8 ? 8'h10 : 8'h20));
      chk(lo_req, mk[i] && i < 8, "low group");
      chk(hi_req, mk[i] && i >= 8, "high group");
      wr(A_FL, 8'h30);
      rd(A_FL, 8'h00);
    end
    wr(A_EN, 8'h00);
    pins(1'b1, chg ^ 12'h101);
    rd(A_FL, 8'h00);
    $display("test change groups done");
    // three sources pending, taken in order once enabled
    wr(A_EN, 8'h31);
    pins(1'b0, chg ^ 12'h101);
    rd(A_FL, 8'h31);
    chk(irq_req, 1'b0, "no global enable");
    @(posedge clk_sys);
    ack_en <= 1'b1;
    gie <= 1'b1;
    wait_n = 0;
    while (n_taken != 2'h3) begin
      @(posedge clk_sys);
      wait_n++;
      if (wait_n > 100) begin
        n_errors++;
        $display("BAD %0t vectors not taken", $time);
        break;
      end
    end
    chk(taken_log, {epiu_pkg::VEC_DEDICATED, epiu_pkg::VEC_GROUP_LOW, epiu_pkg::VEC_GROUP_HIGH},
      "vector order");
    repeat (4) @(posedge clk_sys);
    rd(A_FL, 8'h00);
    chk(irq_req, 1'b0, "all taken");
    $display("test vectors done");
    complete_run();
  end
endmodule

`default_nettype wire
